// ==== hw/fcs_defines.vh ====
// Constants of the flash command sequencer: register map, field positions,
// command codes and reset values.
// Assumes it is included once per design file by its bare name.
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// ================================================================
// Register offsets on the plain register port
`define FCS_REG_CLKDIV   3'h0
`define FCS_REG_STATUS   3'h1
`define FCS_REG_FAULT    3'h2
`define FCS_REG_INDEX    3'h3
`define FCS_REG_PARAM    3'h4
`define FCS_REG_MARGIN   3'h5

// ================================================================
// Status register fields
`define FCS_ST_COMPLETE  7
`define FCS_ST_ACCESS_ERROR_FLAG    5
`define FCS_ST_PVIOL     4
`define FCS_ST_VERR      1
`define FCS_ST_VFATAL    0
// Fault register fields
`define FCS_FT_SINGLE    0
`define FCS_FT_DOUBLE    1
// Margin register fields
`define FCS_MG_PARRAY    0
`define FCS_MG_DARRAY    1

// ================================================================
// Reset values
`define FCS_CLKDIV_RST   8'h00
`define FCS_INDEX_RST    3'h0
`define FCS_PARAM_RST    16'h0000
`define FCS_MARGIN_RST   2'h0

// ================================================================
// Command codes
`define FCS_CMD_VFY_ALL  8'h01
`define FCS_CMD_VFY_BLK  8'h02
`define FCS_CMD_VFY_SECT 8'h03
`define FCS_CMD_RD_ONCE  8'h04
`define FCS_CMD_PROG_P   8'h06
`define FCS_CMD_PROG_ONC 8'h07
`define FCS_CMD_ERS_ALL  8'h08
`define FCS_CMD_ERS_BLK  8'h09
`define FCS_CMD_ERS_PSEC 8'h0a
`define FCS_CMD_UNSECURE 8'h0b
`define FCS_CMD_USR_MRG  8'h0d
`define FCS_CMD_FLD_MRG  8'h0e
`define FCS_CMD_VFY_DSEC 8'h10
`define FCS_CMD_PROG_D   8'h11
`define FCS_CMD_ERS_DSEC 8'h12

// ================================================================
// Block selects, section limit and read-once range
`define FCS_BLK_P        2'h0
`define FCS_BLK_D        2'h1
`define FCS_SECT_LIMIT   20'h20000
`define FCS_ONCE_MAX     16'h0007

// ================================================================
// Operation classes for the concurrency check
`define FCS_CL_NONE      3'h0
`define FCS_CL_READ      3'h1
`define FCS_CL_MREAD     3'h2
`define FCS_CL_PROG      3'h3
`define FCS_CL_SERASE    3'h4
`define FCS_CL_MERASE    3'h5

`endif

// ==== hw/fcs_flag.v ====
// Sticky status flag used by the flash command sequencer.
// Assumes one clock, asynchronous active-low reset, single-cycle set/clear.
module fcs_flag #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst_n,
  // Event and clear
  input  wire set,
  input  wire clr,
  // Flag state
  output reg  flag
);

  // ================================================================
  // Set wins so an event is never lost to a simultaneous clear
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag <= RESET_VAL;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule // fcs_flag

// ==== hw/fcs_sequencer.v ====
// Flash command sequencer: parameter array, launch checks, status flags,
// hand-off to the array engine and invalid-read detection.
// Assumes a flash array engine that answers each start with one done pulse.
//
// What this block does
// - only listed array operation pairings run together
// - non-normal margin level makes reads margin reads
// - erase-all and erase-block count as mass erase
// - program/erase before divider write sets access error
// - unknown command code sets access error, not run
// - reading a busy array returns invalid data
// - invalid read sets both fault flags if clear
// - verify-all is code 01 at index 000
// - clearing complete flag launches; set when done
// - wrong index at launch sets access error
// - verify/read errors set verify flags, never violation
// - verify-block code 02 selects block; bad block errors
// - section verify code 03, launch index 010
// - bad address, misalignment or 128K crossing errors
// - unavailable command in current mode sets error
// - read-once reaches eight reserved phrases, index 0-7
// - read-once code 04 fills slots 010-101
// - read-once makes program-array reads invalid
`include "fcs_defines.vh"

module fcs_sequencer #(
  parameter DW = 16
) (
  // Clock and reset
  input  wire          clk_sys,
  input  wire          rst_n,
  // Register port
  input  wire [2:0]    reg_addr,
  input  wire [DW-1:0] reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [DW-1:0] reg_rdata,
  // Device operating mode
  input  wire          restricted_mode,
  // Array engine
  output reg           arr_start,
  output reg  [7:0]    arr_cmd,
  output reg  [17:0]   arr_addr,
  output reg  [15:0]   arr_count,
  output reg           arr_margin,
  output wire [63:0]   arr_wdata,
  input  wire          arr_done,
  input  wire          arr_rd_err,
  input  wire          arr_rd_fatal,
  input  wire          arr_prot_err,
  input  wire [63:0]   arr_rdata,
  // CPU reads of the arrays
  input  wire          cpu_rd_p,
  input  wire          cpu_rd_d,
  output wire          cpu_rd_invalid,
  // Status
  output reg           command_complete_flag
);

  // ================================================================
  // State machine
  localparam S_IDLE = 2'b01;
  localparam S_BUSY = 2'b10;

  reg  [1:0]    state;
  reg  [7:0]    flash_clock_divider;
  reg           div_written;
  reg  [2:0]    parameter_index_pointer;
  reg  [DW-1:0] command_parameter_array [0:5];
  reg  [1:0]    margin;
  reg           run_p;
  reg           run_d;
  reg  [2:0]    run_cls;
  reg           run_verify;

  wire access_error_flag;
  wire protection_violation_flag;
  wire verify_error_flag;
  wire verify_fatal_flag;
  wire single_fault_flag;
  wire double_fault_flag;

  // ================================================================
  // Command decode of the loaded parameters
  wire [7:0]  cmd   = command_parameter_array[0][15:8];
  wire [1:0]  blk   = command_parameter_array[0][1:0];
  wire [17:0] gaddr = {blk, command_parameter_array[1]};
  wire [19:0] sect_end = {3'h0, gaddr[16:0]} + {1'b0, command_parameter_array[2], 3'h0};

  reg       c_valid;
  reg       c_pe;
  reg [2:0] c_idx_min;
  reg [2:0] c_idx_max;
  reg       c_touch_p;
  reg       c_touch_d;
  reg [2:0] c_cls;
  reg       c_verify;
  reg       c_bad;
  reg       c_mode_only;

  always @* begin
    c_valid     = 1'b1;
    c_pe        = 1'b0;
    c_idx_min   = 3'h0;
    c_idx_max   = 3'h0;
    c_touch_p   = 1'b0;
    c_touch_d   = 1'b0;
    c_cls       = `FCS_CL_NONE;
    c_verify    = 1'b0;
    c_bad       = 1'b0;
    c_mode_only = 1'b0;
    case (cmd)
      `FCS_CMD_VFY_ALL: begin
        c_touch_p = 1'b1;
        c_touch_d = 1'b1;
        c_verify  = 1'b1;
      end
      `FCS_CMD_VFY_BLK: begin
        c_touch_p = (blk == `FCS_BLK_P);
        c_touch_d = (blk == `FCS_BLK_D);
        c_bad     = (blk != `FCS_BLK_P) && (blk != `FCS_BLK_D);
        c_verify  = 1'b1;
      end
      `FCS_CMD_VFY_SECT: begin
        c_idx_min   = 3'h2;
        c_idx_max   = 3'h2;
        c_touch_p   = 1'b1;
        c_verify    = 1'b1;
        c_mode_only = 1'b1;
        c_bad = (blk != `FCS_BLK_P) || (gaddr[2:0] != 3'h0)
                || (sect_end > `FCS_SECT_LIMIT);
      end
      `FCS_CMD_RD_ONCE: begin
        c_idx_min   = 3'h1;
        c_idx_max   = 3'h1;
        c_touch_p   = 1'b1;
        c_verify    = 1'b1;
        c_mode_only = 1'b1;
        c_bad = (command_parameter_array[1] > `FCS_ONCE_MAX);
      end
      `FCS_CMD_PROG_P, `FCS_CMD_PROG_ONC: begin
        c_pe      = 1'b1;
        c_idx_min = 3'h5;
        c_idx_max = 3'h5;
        c_touch_p = 1'b1;
        c_cls     = `FCS_CL_PROG;
      end
      `FCS_CMD_ERS_ALL, `FCS_CMD_UNSECURE: begin
        c_pe      = 1'b1;
        c_touch_p = 1'b1;
        c_touch_d = 1'b1;
        c_cls     = `FCS_CL_MERASE;
      end
      `FCS_CMD_ERS_BLK: begin
        c_pe      = 1'b1;
        c_touch_p = (blk == `FCS_BLK_P);
        c_touch_d = (blk == `FCS_BLK_D);
        c_bad     = (blk != `FCS_BLK_P) && (blk != `FCS_BLK_D);
        c_cls     = `FCS_CL_MERASE;
      end
      `FCS_CMD_ERS_PSEC: begin
        c_pe      = 1'b1;
        c_idx_min = 3'h1;
        c_idx_max = 3'h1;
        c_touch_p = 1'b1;
        c_cls     = `FCS_CL_SERASE;
      end
      `FCS_CMD_USR_MRG, `FCS_CMD_FLD_MRG: begin
        c_idx_min   = 3'h1;
        c_idx_max   = 3'h1;
        c_mode_only = (cmd == `FCS_CMD_FLD_MRG);
        c_bad       = (blk != `FCS_BLK_P) && (blk != `FCS_BLK_D);
      end
      `FCS_CMD_VFY_DSEC: begin
        c_idx_min = 3'h2;
        c_idx_max = 3'h2;
        c_touch_d = 1'b1;
        c_verify  = 1'b1;
      end
      `FCS_CMD_PROG_D: begin
        c_pe      = 1'b1;
        c_idx_min = 3'h2;
        c_idx_max = 3'h5;
        c_touch_d = 1'b1;
        c_cls     = `FCS_CL_PROG;
      end
      `FCS_CMD_ERS_DSEC: begin
        c_pe      = 1'b1;
        c_idx_min = 3'h1;
        c_idx_max = 3'h1;
        c_touch_d = 1'b1;
        c_cls     = `FCS_CL_SERASE;
      end
      default: begin
        c_valid = 1'b0;
      end
    endcase
  end

  // Verify reads are margin reads once a non-normal level is chosen
  wire       c_margin = (c_touch_p & margin[`FCS_MG_PARRAY])
                        | (c_touch_d & margin[`FCS_MG_DARRAY]);
  wire [2:0] c_class  = c_verify ? (c_margin ? `FCS_CL_MREAD : `FCS_CL_READ) : c_cls;

  wire launch_err = !c_valid
                    || (c_pe && !div_written)
                    || (parameter_index_pointer < c_idx_min)
                    || (parameter_index_pointer > c_idx_max)
                    || c_bad
                    || (c_mode_only && restricted_mode);

  // ================================================================
  // Register writes and launch
  wire busy     = state[1];
  wire wr_stat  = reg_wr && (reg_addr == `FCS_REG_STATUS);
  wire wr_fault = reg_wr && (reg_addr == `FCS_REG_FAULT);
  // Launch is refused while an access error or protection violation stands, so stale errors cannot mask new ones
  wire launch   = wr_stat && reg_wdata[`FCS_ST_COMPLETE] && !busy
                  && !access_error_flag && !protection_violation_flag;
  wire go       = launch && !launch_err;
  wire finish   = busy && arr_done;
  wire is_once  = (arr_cmd == `FCS_CMD_RD_ONCE);

  assign arr_wdata = {command_parameter_array[5], command_parameter_array[4],
                      command_parameter_array[3], command_parameter_array[2]};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flash_clock_divider     <= `FCS_CLKDIV_RST;
      div_written             <= 1'b0;
      parameter_index_pointer <= `FCS_INDEX_RST;
      margin                  <= `FCS_MARGIN_RST;
    end else begin
      if (reg_wr && (reg_addr == `FCS_REG_CLKDIV) && !busy) begin
        flash_clock_divider <= reg_wdata[7:0];
        div_written         <= 1'b1;
      end
      if (reg_wr && (reg_addr == `FCS_REG_INDEX) && !busy) begin
        parameter_index_pointer <= reg_wdata[2:0];
      end
      if (reg_wr && (reg_addr == `FCS_REG_MARGIN) && !busy) begin
        margin <= reg_wdata[1:0];
      end else if (finish && ((arr_cmd == `FCS_CMD_USR_MRG)
                              || (arr_cmd == `FCS_CMD_FLD_MRG))) begin
        margin[arr_addr[16]] <= (command_parameter_array[1] != `FCS_PARAM_RST);
      end
    end
  end

  // ================================================================
  // Parameter array: software writes when idle, read-once fills on finish
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_param
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          command_parameter_array[gi] <= `FCS_PARAM_RST;
        end else if (finish && is_once && (gi >= 2)) begin
          command_parameter_array[gi] <= arr_rdata[16*((gi+2)%4) +: 16];
        end else if (reg_wr && (reg_addr == `FCS_REG_PARAM) && !busy
                     && (parameter_index_pointer == gi)) begin
          command_parameter_array[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ================================================================
  // Sequencer state machine and array engine hand-off
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state                 <= S_IDLE;
      command_complete_flag <= 1'b1;
      arr_start             <= 1'b0;
      arr_cmd               <= 8'h00;
      arr_addr              <= 18'h00000;
      arr_count             <= 16'h0000;
      arr_margin            <= 1'b0;
      run_p                 <= 1'b0;
      run_d                 <= 1'b0;
      run_cls               <= `FCS_CL_NONE;
      run_verify            <= 1'b0;
    end else begin
      arr_start <= 1'b0;
      case (state)
        S_IDLE: begin
          if (go) begin
            state                 <= S_BUSY;
            command_complete_flag <= 1'b0;
            arr_start             <= 1'b1;
            arr_cmd               <= cmd;
            arr_addr              <= gaddr;
            arr_count             <= command_parameter_array[2];
            arr_margin            <= c_margin;
            run_p                 <= c_touch_p;
            run_d                 <= c_touch_d;
            run_cls               <= c_class;
            run_verify            <= c_verify;
          end
        end
        S_BUSY: begin
          if (arr_done) begin
            state                 <= S_IDLE;
            command_complete_flag <= 1'b1;
            run_p                 <= 1'b0;
            run_d                 <= 1'b0;
            run_cls               <= `FCS_CL_NONE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ================================================================
  // Status flags
  fcs_flag u_access_error_flag (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     (launch && launch_err),
    .clr     (wr_stat && reg_wdata[`FCS_ST_ACCESS_ERROR_FLAG]),
    .flag    (access_error_flag)
  );

  fcs_flag u_pviol (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     (finish && arr_prot_err && !run_verify),
    .clr     (wr_stat && reg_wdata[`FCS_ST_PVIOL]),
    .flag    (protection_violation_flag)
  );

  // Verify flags describe the last command only, so a launch that starts a command wipes them
  fcs_flag u_verr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     (finish && arr_rd_err),
    .clr     (go),
    .flag    (verify_error_flag)
  );

  fcs_flag u_vfatal (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     (finish && arr_rd_fatal),
    .clr     (go),
    .flag    (verify_fatal_flag)
  );

  // ================================================================
  // Reads of the arrays while a command runs
  function pair_ok;
    input [2:0] pcl;
    input [2:0] dcl;
    begin
      pair_ok = ((pcl == `FCS_CL_READ) && ((dcl == `FCS_CL_MREAD)
                 || (dcl == `FCS_CL_PROG) || (dcl == `FCS_CL_SERASE)))
                || ((pcl == `FCS_CL_MREAD) && (dcl == `FCS_CL_MREAD))
                || ((pcl == `FCS_CL_SERASE) && (dcl == `FCS_CL_SERASE))
                || ((pcl == `FCS_CL_MERASE) && (dcl == `FCS_CL_MERASE));
    end
  endfunction

  wire [2:0] p_rd_cls = margin[`FCS_MG_PARRAY] ? `FCS_CL_MREAD : `FCS_CL_READ;
  wire [2:0] d_rd_cls = margin[`FCS_MG_DARRAY] ? `FCS_CL_MREAD : `FCS_CL_READ;

  // Read-once marks the program array busy, so its reads come back invalid
  wire bad_p = cpu_rd_p && (run_p || (run_d && !pair_ok(p_rd_cls, run_cls)));
  wire bad_d = cpu_rd_d && (run_d || (run_p && !pair_ok(run_cls, d_rd_cls)));

  assign cpu_rd_invalid = busy && (bad_p || bad_d);

  wire fault_new = cpu_rd_invalid && !single_fault_flag && !double_fault_flag;

  fcs_flag u_sfault (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     (fault_new),
    .clr     (wr_fault && reg_wdata[`FCS_FT_SINGLE]),
    .flag    (single_fault_flag)
  );

  fcs_flag u_dfault (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     (fault_new),
    .clr     (wr_fault && reg_wdata[`FCS_FT_DOUBLE]),
    .flag    (double_fault_flag)
  );

  // ================================================================
  // Register read-back, one cycle after the strobe
  reg [DW-1:0] next_rdata;

  always @* begin
    next_rdata = {DW{1'b0}};
    case (reg_addr)
      `FCS_REG_CLKDIV: next_rdata[7:0] = flash_clock_divider;
      `FCS_REG_STATUS: begin
        next_rdata[`FCS_ST_COMPLETE] = command_complete_flag;
        next_rdata[`FCS_ST_ACCESS_ERROR_FLAG]   = access_error_flag;
        next_rdata[`FCS_ST_PVIOL]    = protection_violation_flag;
        next_rdata[`FCS_ST_VERR]     = verify_error_flag;
        next_rdata[`FCS_ST_VFATAL]   = verify_fatal_flag;
      end
      `FCS_REG_FAULT: begin
        next_rdata[`FCS_FT_SINGLE] = single_fault_flag;
        next_rdata[`FCS_FT_DOUBLE] = double_fault_flag;
      end
      `FCS_REG_INDEX:  next_rdata[2:0] = parameter_index_pointer;
      `FCS_REG_PARAM: begin
        if (parameter_index_pointer < 3'h6) begin
          next_rdata = command_parameter_array[parameter_index_pointer];
        end
      end
      `FCS_REG_MARGIN: next_rdata[1:0] = margin;
      default:         next_rdata = {DW{1'b0}};
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= {DW{1'b0}};
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= {DW{1'b0}};
    end
  end

endmodule // fcs_sequencer

// ==== sim/fcs_engine_model.sv ====
// Behavioural array engine facing the sequencer.
// Assumes one done pulse per start, after a delay set by the bench.
module fcs_engine_model (
  // Clock and reset
  input  logic        clk_sys,
  input  logic        rst_n,
  // Sequencer side
  input  logic        arr_start,
  output logic        arr_done,
  output logic        arr_rd_err,
  output logic        arr_rd_fatal,
  output logic        arr_prot_err,
  output logic [63:0] arr_rdata,
  // Bench controls
  input  logic [7:0]  dly,
  input  logic [2:0]  errs,
  input  logic [63:0] phrase
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic       busy;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt  <= 8'h00;
    end else if (arr_start) begin
      busy <= 1'b1;
      cnt  <= dly;
    end else if (busy && cnt == 8'h00) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
    end
  end
  assign arr_done = busy && cnt == 8'h00;
  // Result lines mean nothing away from done, so they show junk there
  assign {arr_prot_err, arr_rd_fatal, arr_rd_err} = arr_done ? errs : ~errs;
  assign arr_rdata = arr_done ? phrase : ~phrase;
endmodule // fcs_engine_model

// ==== sim/fcs_sequencer_sva.sv ====
// Checker for the flash command sequencer, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
module fcs_sequencer_sva #(
  parameter DW = 16
) (
  // Clock and reset
  input logic          clk_sys,
  input logic          rst_n,
  // Register port
  input logic [2:0]    reg_addr,
  input logic [DW-1:0] reg_wdata,
  input logic          reg_wr,
  // Array engine and CPU reads
  input logic          arr_start,
  input logic [7:0]    arr_cmd,
  input logic          arr_done,
  input logic          cpu_rd_p,
  input logic          cpu_rd_d,
  input logic          cpu_rd_invalid,
  input logic          command_complete_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ================================================================
  // Launch and completion
  sequence s_launch_wr;
    reg_wr && reg_addr == 3'h1 && reg_wdata[7];
  endsequence
  sequence s_busy_launch;
    !command_complete_flag ##0 s_launch_wr;
  endsequence
  property p_start_cause;
    $rose(arr_start) |-> $past(reg_wr) && $past(reg_addr) == 3'h1 && $past(reg_wdata[7]);
  endproperty
  property p_start_single;
    arr_start |-> !command_complete_flag ##1 (!arr_start && !command_complete_flag);
  endproperty
  property p_busy_refuse;
    s_busy_launch |=> !arr_start;
  endproperty
  property p_done_sets;
    arr_done && !command_complete_flag |=> command_complete_flag;
  endproperty
  property p_fall_start;
    $fell(command_complete_flag) |-> arr_start;
  endproperty
  property p_stay_busy;
    !command_complete_flag && !arr_done |=> !command_complete_flag;
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without launch");
  a_start_single: assert property (p_start_single) else $error("start pulse bad");
  a_busy_refuse: assert property (p_busy_refuse) else $error("launch taken busy");
  a_done_sets: assert property (p_done_sets) else $error("done did not complete");
  a_fall_start: assert property (p_fall_start) else $error("busy without start");
  a_stay_busy: assert property (p_stay_busy) else $error("completed without done");

  // ================================================================
  // Invalid reads
  property p_once_blocks;
    !command_complete_flag && arr_cmd == 8'h04 && cpu_rd_p |-> cpu_rd_invalid;
  endproperty
  property p_same_block;
    !command_complete_flag && arr_cmd == 8'h12 && cpu_rd_d |-> cpu_rd_invalid;
  endproperty
  property p_idle_valid;
    command_complete_flag && (cpu_rd_p || cpu_rd_d) |-> !cpu_rd_invalid;
  endproperty
  a_once_blocks: assert property (p_once_blocks) else $error("read-once read valid");
  a_same_block: assert property (p_same_block) else $error("busy block read valid");
  a_idle_valid: assert property (p_idle_valid) else $error("idle read invalid");
endmodule // fcs_sequencer_sva

// ==== sim/tb_top.sv ====
// Self-checking bench for the flash command sequencer.
// Assumes the engine model and checker files are compiled before it.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] p0, p1, p2; logic [2:0] ix; logic rm, bad;} fcs_row_t;
  typedef struct packed {logic [15:0] p0; logic [2:0] ix; logic [1:0] mg; logic rp, inv;} fcs_cc_t;
  logic        clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        restricted_mode = 1'b0, cpu_rd_p = 1'b0, cpu_rd_d = 1'b0;
  logic [2:0]  reg_addr = 3'h0, errs = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [17:0] arr_addr;
  logic [7:0]  dly = 8'h04, arr_cmd;
  logic [63:0] phrase = 64'h4444_3333_2222_1111, arr_rdata;
  logic        arr_start, arr_margin, arr_done, arr_rd_err, arr_rd_fatal, arr_prot_err;
  logic        cpu_rd_invalid, command_complete_flag;
  int          err_total = 0, checks = 0, n_start = 0, cyc = 0, s0;
  fcs_row_t rows [14] = '{
    '{16'h0100, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b0}, '{16'h0100, 16'h0000, 16'h0000, 3'h1, 1'b0, 1'b1},
    '{16'h0201, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b0}, '{16'h0202, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b1},
    '{16'h0300, 16'h0000, 16'h0004, 3'h2, 1'b0, 1'b0}, '{16'h0300, 16'h0000, 16'h0004, 3'h1, 1'b0, 1'b1},
    '{16'h0300, 16'h0004, 16'h0004, 3'h2, 1'b0, 1'b1}, '{16'h0300, 16'hfff8, 16'h2001, 3'h2, 1'b0, 1'b0},
    '{16'h0300, 16'hfff8, 16'h2002, 3'h2, 1'b0, 1'b1}, '{16'h0300, 16'h0000, 16'h0004, 3'h2, 1'b1, 1'b1},
    '{16'h0400, 16'h0007, 16'h0000, 3'h1, 1'b0, 1'b0}, '{16'h0400, 16'h0008, 16'h0000, 3'h1, 1'b0, 1'b1},
    '{16'h0400, 16'h0000, 16'h0000, 3'h1, 1'b1, 1'b1}, '{16'h0500, 16'h0000, 16'h0000, 3'h0, 1'b0, 1'b1}};
  fcs_cc_t cc [5] = '{'{16'h0201, 3'h0, 2'h2, 1'b1, 1'b0}, '{16'h0201, 3'h0, 2'h0, 1'b1, 1'b1},
    '{16'h1201, 3'h1, 2'h0, 1'b1, 1'b0}, '{16'h1201, 3'h1, 2'h0, 1'b0, 1'b1},
    '{16'h0901, 3'h0, 2'h0, 1'b1, 1'b1}};

  fcs_sequencer #(.DW(16)) uut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .restricted_mode, .arr_start, .arr_cmd, .arr_addr, .arr_count(), .arr_margin,
    .arr_wdata(), .arr_done, .arr_rd_err, .arr_rd_fatal, .arr_prot_err, .arr_rdata, .cpu_rd_p,
    .cpu_rd_d, .cpu_rd_invalid, .command_complete_flag);
  fcs_engine_model eng (.clk_sys, .rst_n, .arr_start, .arr_done, .arr_rd_err, .arr_rd_fatal,
    .arr_prot_err, .arr_rdata, .dly, .errs, .phrase);

  // ================================================================
  // Clock, watchdog and shared tasks
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (arr_start === 1'b1) n_start <= n_start + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes drop with a gap cycle so no signal is driven twice in one step
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string what);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, what);
    @(posedge clk_sys);
  endtask
  task automatic cmd(input logic [15:0] p0, p1, p2, input logic [2:0] ix);
    wr(3'h3, 16'h0000);
    wr(3'h4, p0);
    wr(3'h3, 16'h0001);
    wr(3'h4, p1);
    wr(3'h3, 16'h0002);
    wr(3'h4, p2);
    wr(3'h3, {13'h0000, ix});
    wr(3'h1, 16'h0080);
  endtask
  task automatic wait_done;
    int n = 0;
    @(posedge clk_sys);
    while (command_complete_flag !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 300, 1'b1, "completion wait");
  endtask
  task automatic probe(input logic p, input logic exp, input string what);
    cpu_rd_p <= p;
    cpu_rd_d <= !p;
    #1 chk(cpu_rd_invalid, exp, what);
    @(posedge clk_sys);
    cpu_rd_p <= 1'b0;
    cpu_rd_d <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ================================================================
  // Main sequence
  initial begin
    do_reset();
    foreach (rows[i]) begin
      s0 = n_start;
      restricted_mode <= rows[i].rm;
      cmd(rows[i].p0, rows[i].p1, rows[i].p2, rows[i].ix);
      wait_done();
      rd(3'h1, {10'h002, rows[i].bad, 5'h00}, "status");
      chk(n_start - s0, !rows[i].bad, "starts");
      if (!rows[i].bad) chk(arr_addr, {rows[i].p0[1:0], rows[i].p1}, "address");
      wr(3'h1, 16'h0020);
      $display("row %0d done", i);
    end
    restricted_mode <= 1'b0;
    do_reset();
    rd(3'h1, 16'h0080, "status after reset");
    rd(3'h0, 16'h0000, "divider after reset");
    rd(3'h3, 16'h0000, "index after reset");
    rd(3'h7, 16'h0000, "unmapped");
    probe(1'b1, 1'b0, "idle read");
    s0 = n_start;
    cmd(16'h0800, 16'h0000, 16'h0000, 3'h0);
    cmd(16'h0100, 16'h0000, 16'h0000, 3'h0);
    rd(3'h1, 16'h00a0, "no divider");
    chk(n_start - s0, 0, "blocked starts");
    wr(3'h1, 16'h0020);
    wr(3'h0, 16'h0004);
    $display("reset and divider test done");
    dly <= 8'h28;
    foreach (cc[i]) begin
      wr(3'h5, {14'h0000, cc[i].mg});
      cmd(cc[i].p0, 16'h0000, 16'h0000, cc[i].ix);
      probe(cc[i].rp, cc[i].inv, "pairing");
      chk(arr_margin, cc[i].mg != 2'h0, "margin");
      wait_done();
    end
    $display("pairing test done");
    errs <= 3'h7;
    cmd(16'h0100, 16'h0000, 16'h0000, 3'h0);
    wait_done();
    rd(3'h1, 16'h0083, "verify flags");
    errs <= 3'h0;
    wr(3'h2, 16'h0003);
    cmd(16'h0400, 16'h0007, 16'h0000, 3'h1);
    probe(1'b1, 1'b1, "read during read-once");
    wr(3'h3, 16'h0005);
    wr(3'h1, 16'h0080);
    wait_done();
    rd(3'h2, 16'h0003, "fault flags");
    rd(3'h3, 16'h0001, "index kept");
    for (int k = 2; k < 6; k++) begin
      wr(3'h3, k[15:0]);
      rd(3'h4, phrase[16*(k-2) +: 16], "read-once word");
    end
    wr(3'h2, 16'h0003);
    rd(3'h2, 16'h0000, "fault clear");
    $display("read-once test done");
    stop_test();
  end
endmodule // tb_top

bind fcs_sequencer fcs_sequencer_sva #(.DW(DW)) u_sva (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .arr_start, .arr_cmd, .arr_done, .cpu_rd_p, .cpu_rd_d, .cpu_rd_invalid,
  .command_complete_flag);
